// [inc/tmr3_pkg.sv]
package tmr3_pkg;
  // register addresses
  localparam logic [7:0] ADDR_CONTROL = 8'h91;
  localparam logic [7:0] ADDR_RELOAD_LOW = 8'h92;
  localparam logic [7:0] ADDR_RELOAD_HIGH = 8'h93;
  localparam logic [7:0] ADDR_COUNT_LOW = 8'h94;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'h95;
  // control field positions
  localparam int BIT_HIGH_FLAG = 7;
  localparam int BIT_LOW_FLAG = 6;
  localparam int BIT_LOW_IRQ_EN = 5;
  localparam int BIT_CAPTURE_EN = 4;
  localparam int BIT_SPLIT = 3;
  localparam int BIT_RUN = 2;
  localparam int BIT_CAPTURE_SRC = 1;
  localparam int BIT_EXT_SEL = 0;
  // reset values and limits
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] BYTE_MAX = 8'hff;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [3:0] DIV12_LAST = 4'hb;
  localparam logic [3:0] DIV_ZERO = 4'h0;
  localparam logic [3:0] DIV_ONE = 4'h1;
  // special-function register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tmr3_sfr_s;
  // per-byte tick sources
  typedef struct packed {
    logic sys;
    logic div12;
    logic ext8;
  } tmr3_tick_s;
endpackage : tmr3_pkg

// [hdl/tmr3_timer.sv]
module tmr3_timer (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // special-function register access
  input wire tmr3_pkg::tmr3_sfr_s sfr,
  output logic [7:0] sfr_rdata,
  // clock select and interrupt enable bits held elsewhere
  input wire logic high_byte_fast_clock_select,
  input wire logic low_byte_fast_clock_select,
  input wire logic timer_irq_enable,
  // event sources
  input wire logic ext_clk_div8,
  input wire logic usb_sof,
  input wire logic slow_internal_oscillator,
  // interrupt request
  output logic irq
);

  // stored state
  logic [7:0] control, next_control;
  logic [7:0] count_low_byte, next_count_low_byte;
  logic [7:0] count_high_byte, next_count_high_byte;
  logic [7:0] reload_low_byte, next_reload_low_byte;
  logic [7:0] reload_high_byte, next_reload_high_byte;
  logic [3:0] div12, next_div12;
  logic [2:0] ext_sync, sof_sync, lfo_sync; // sync stages plus history
  logic [2:0] next_ext_sync, next_sof_sync, next_lfo_sync; // shifted stages
  logic irq_q, next_irq;
  logic [7:0] rdata_q, next_rdata;

  // decoded controls
  logic split_byte_mode, run_control, capture_mode_enable;
  logic capture_source_select, external_tick_select, low_overflow_irq_enable;
  logic ext_pulse, sof_pulse, lfo_pulse, capture_pulse;
  logic div12_pulse, tick_low, tick_high, run_low, run_high;
  logic low_wrap, high_wrap, wide_wrap;
  tmr3_pkg::tmr3_tick_s src;

  // field decode
  always_comb begin
    split_byte_mode = control[tmr3_pkg::BIT_SPLIT];
    run_control = control[tmr3_pkg::BIT_RUN];
    capture_mode_enable = control[tmr3_pkg::BIT_CAPTURE_EN];
    capture_source_select = control[tmr3_pkg::BIT_CAPTURE_SRC];
    external_tick_select = control[tmr3_pkg::BIT_EXT_SEL];
    low_overflow_irq_enable = control[tmr3_pkg::BIT_LOW_IRQ_EN];
  end

  // edge pulses read only the second and third stages
  always_comb begin
    ext_pulse = ext_sync[1] & ~ext_sync[2];
    sof_pulse = sof_sync[1] & ~sof_sync[2];
    lfo_pulse = ~lfo_sync[1] & lfo_sync[2]; // falling edge
    capture_pulse = capture_mode_enable &
      (capture_source_select ? lfo_pulse : sof_pulse);
  end

  // synchroniser next values: each line moves up one stage per clock
  always_comb begin
    next_ext_sync = {ext_sync[1:0], ext_clk_div8};
    next_sof_sync = {sof_sync[1:0], usb_sof};
    next_lfo_sync = {lfo_sync[1:0], slow_internal_oscillator};
  end

  // synchroniser stages; cleared so a rising idle line gives no false fall
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ext_sync <= '0;
      sof_sync <= '0;
      lfo_sync <= '0;
    end else begin
      ext_sync <= next_ext_sync;
      sof_sync <= next_sof_sync;
      lfo_sync <= next_lfo_sync;
    end
  end

  // divide-by-12 prescaler
  always_comb begin
    div12_pulse = (div12 == tmr3_pkg::DIV12_LAST);
    next_div12 = div12_pulse ? tmr3_pkg::DIV_ZERO : div12 + tmr3_pkg::DIV_ONE;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      div12 <= tmr3_pkg::DIV_ZERO;
    end else begin
      div12 <= next_div12;
    end
  end

  // tick selection per byte
  always_comb begin
    src.sys = 1'b1;
    src.div12 = div12_pulse;
    src.ext8 = ext_pulse;
    tick_low = low_byte_fast_clock_select ? src.sys :
      (external_tick_select ? src.ext8 : src.div12);
    tick_high = high_byte_fast_clock_select ? src.sys :
      (external_tick_select ? src.ext8 : src.div12);
  end

  // counting and wrap detection
  always_comb begin
    // split low byte always runs; otherwise run bit gates all
    run_low = split_byte_mode ? 1'b1 : run_control;
    run_high = run_control;
    if (split_byte_mode) begin
      low_wrap = run_low & tick_low & (count_low_byte == tmr3_pkg::BYTE_MAX);
      high_wrap = run_high & tick_high & (count_high_byte == tmr3_pkg::BYTE_MAX);
      wide_wrap = 1'b0;
    end else begin
      // wide counter advances on the low byte's tick
      low_wrap = run_low & tick_low & (count_low_byte == tmr3_pkg::BYTE_MAX);
      wide_wrap = low_wrap & (count_high_byte == tmr3_pkg::BYTE_MAX);
      high_wrap = wide_wrap;
    end
  end

  // next-state for counters, reloads and control
  always_comb begin
    next_count_low_byte = count_low_byte;
    next_count_high_byte = count_high_byte;
    next_reload_low_byte = reload_low_byte;
    next_reload_high_byte = reload_high_byte;
    next_control = control;
    if (split_byte_mode) begin
      // two independent byte timers
      if (run_low && tick_low) begin
        if (low_wrap && !capture_mode_enable) begin
          next_count_low_byte = reload_low_byte;
        end else begin
          next_count_low_byte = count_low_byte + tmr3_pkg::BYTE_ONE;
        end
      end
      if (run_high && tick_high) begin
        if (high_wrap && !capture_mode_enable) begin
          next_count_high_byte = reload_high_byte;
        end else begin
          next_count_high_byte = count_high_byte + tmr3_pkg::BYTE_ONE;
        end
      end
    end else if (run_low && tick_low) begin
      if (wide_wrap && !capture_mode_enable) begin
        next_count_low_byte = reload_low_byte;
        next_count_high_byte = reload_high_byte;
      end else begin
        // free 16-bit increment, wraps to zero in capture mode
        next_count_low_byte = count_low_byte + tmr3_pkg::BYTE_ONE;
        if (low_wrap) begin
          next_count_high_byte = count_high_byte + tmr3_pkg::BYTE_ONE;
        end
      end
    end
    // capture copies the present count
    if (capture_pulse) begin
      next_reload_low_byte = count_low_byte;
      next_reload_high_byte = count_high_byte;
    end
    // software writes
    if (sfr.wr) begin
      unique case (sfr.addr)
        tmr3_pkg::ADDR_CONTROL: next_control = sfr.wdata;
        tmr3_pkg::ADDR_RELOAD_LOW: next_reload_low_byte = sfr.wdata;
        tmr3_pkg::ADDR_RELOAD_HIGH: next_reload_high_byte = sfr.wdata;
        tmr3_pkg::ADDR_COUNT_LOW: next_count_low_byte = sfr.wdata;
        tmr3_pkg::ADDR_COUNT_HIGH: next_count_high_byte = sfr.wdata;
        default: ; // other addresses belong elsewhere
      endcase
    end
    // hardware sets win over a software clear; never cleared here
    if (low_wrap) begin
      next_control[tmr3_pkg::BIT_LOW_FLAG] = 1'b1;
    end
    if (high_wrap) begin
      next_control[tmr3_pkg::BIT_HIGH_FLAG] = 1'b1;
    end
  end

  // interrupt request and read data
  always_comb begin
    next_irq = timer_irq_enable &
      (high_wrap | capture_pulse |
       (low_overflow_irq_enable & low_wrap));
    unique case (sfr.addr)
      tmr3_pkg::ADDR_CONTROL: next_rdata = control;
      tmr3_pkg::ADDR_RELOAD_LOW: next_rdata = reload_low_byte;
      tmr3_pkg::ADDR_RELOAD_HIGH: next_rdata = reload_high_byte;
      tmr3_pkg::ADDR_COUNT_LOW: next_rdata = count_low_byte;
      tmr3_pkg::ADDR_COUNT_HIGH: next_rdata = count_high_byte;
      default: next_rdata = tmr3_pkg::RESET_BYTE;
    endcase
    if (!sfr.rd) begin
      next_rdata = rdata_q; // hold last read
    end
  end

  // state registers
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      control <= tmr3_pkg::RESET_BYTE;
      count_low_byte <= tmr3_pkg::RESET_BYTE;
      count_high_byte <= tmr3_pkg::RESET_BYTE;
      reload_low_byte <= tmr3_pkg::RESET_BYTE;
      reload_high_byte <= tmr3_pkg::RESET_BYTE;
      irq_q <= 1'b0;
      rdata_q <= tmr3_pkg::RESET_BYTE;
    end else begin
      control <= next_control;
      count_low_byte <= next_count_low_byte;
      count_high_byte <= next_count_high_byte;
      reload_low_byte <= next_reload_low_byte;
      reload_high_byte <= next_reload_high_byte;
      irq_q <= next_irq;
      rdata_q <= next_rdata;
    end
  end

  // outputs from flip-flops
  assign irq = irq_q;
  assign sfr_rdata = rdata_q;

  // checks
  chk_wide_reload: assert property (@(posedge mclk) disable iff (!resetn)
    (wide_wrap && !capture_mode_enable && !sfr.wr) |=>
      ({count_high_byte, count_low_byte} == $past({reload_high_byte, reload_low_byte})))
    else $error("wide wrap did not reload");
  chk_high_flag_set: assert property (@(posedge mclk) disable iff (!resetn)
    high_wrap |=> control[tmr3_pkg::BIT_HIGH_FLAG])
    else $error("high flag not set on wrap");
  chk_low_flag_set: assert property (@(posedge mclk) disable iff (!resetn)
    low_wrap |=> control[tmr3_pkg::BIT_LOW_FLAG])
    else $error("low flag not set on wrap");
  chk_flag_sticky: assert property (@(posedge mclk) disable iff (!resetn)
    (control[tmr3_pkg::BIT_HIGH_FLAG] && !(sfr.wr && sfr.addr == tmr3_pkg::ADDR_CONTROL))
      |=> control[tmr3_pkg::BIT_HIGH_FLAG])
    else $error("high flag cleared by hardware");
  chk_irq_high: assert property (@(posedge mclk) disable iff (!resetn)
    (high_wrap && timer_irq_enable) |=> irq)
    else $error("missing overflow interrupt");
  chk_irq_low_gate: assert property (@(posedge mclk) disable iff (!resetn)
    (low_wrap && !high_wrap && !capture_pulse && !low_overflow_irq_enable) |=> !irq)
    else $error("low wrap interrupted without enable");
  chk_capture_copy: assert property (@(posedge mclk) disable iff (!resetn)
    (capture_pulse && !sfr.wr) |=>
      ({reload_high_byte, reload_low_byte} == $past({count_high_byte, count_low_byte})))
    else $error("capture did not copy count");
  chk_split_low_run: assert property (@(posedge mclk) disable iff (!resetn)
    (split_byte_mode && !run_control && low_byte_fast_clock_select && !sfr.wr
      && count_low_byte != tmr3_pkg::BYTE_MAX)
      |=> count_low_byte == $past(count_low_byte) + tmr3_pkg::BYTE_ONE)
    else $error("split low byte stalled");
  chk_stopped_high: assert property (@(posedge mclk) disable iff (!resetn)
    (!run_control && !sfr.wr && !capture_pulse) |=> $stable(count_high_byte))
    else $error("high byte moved while stopped");

  // low byte also stands still when the wide counter is stopped
  chk_stopped_low: assert property (@(posedge mclk) disable iff (!resetn)
    (!split_byte_mode && !run_control && !sfr.wr)
      |=> $stable(count_low_byte))
    else $error("low byte moved while stopped");

  // low flag is as sticky as the high flag
  chk_low_sticky: assert property (@(posedge mclk) disable iff (!resetn)
    (control[tmr3_pkg::BIT_LOW_FLAG] && !(sfr.wr && sfr.addr == tmr3_pkg::ADDR_CONTROL))
      |=> control[tmr3_pkg::BIT_LOW_FLAG])
    else $error("low flag cleared by hardware");

  // software write lands whole when no wrap competes with it
  chk_write_control: assert property (@(posedge mclk) disable iff (!resetn)
    (sfr.wr && sfr.addr == tmr3_pkg::ADDR_CONTROL && !low_wrap && !high_wrap)
      |=> control == $past(sfr.wdata))
    else $error("control write lost");

  // low wrap without a wide wrap carries into the high byte
  chk_wide_carry: assert property (@(posedge mclk) disable iff (!resetn)
    (!split_byte_mode && low_wrap && !wide_wrap && !sfr.wr)
      |=> count_high_byte == $past(count_high_byte) + tmr3_pkg::BYTE_ONE)
    else $error("no carry into high byte");

  // fast select advances the running wide counter every clock
  chk_fast_tick: assert property (@(posedge mclk) disable iff (!resetn)
    (!split_byte_mode && run_control && low_byte_fast_clock_select && !sfr.wr
      && count_low_byte != tmr3_pkg::BYTE_MAX)
      |=> count_low_byte == $past(count_low_byte) + tmr3_pkg::BYTE_ONE)
    else $error("fast tick missed");

  // prescaler never leaves its twelve states
  chk_div12_range: assert property (@(posedge mclk) disable iff (!resetn)
    div12 <= tmr3_pkg::DIV12_LAST)
    else $error("prescaler out of range");

  // split low byte reloads from its own reload byte
  chk_split_low_reload: assert property (@(posedge mclk) disable iff (!resetn)
    (split_byte_mode && low_wrap && !capture_mode_enable && !sfr.wr)
      |=> count_low_byte == $past(reload_low_byte))
    else $error("split low byte did not reload");

  // split high byte reloads from its own reload byte
  chk_split_high_reload: assert property (@(posedge mclk) disable iff (!resetn)
    (split_byte_mode && high_wrap && !capture_mode_enable && !sfr.wr)
      |=> count_high_byte == $past(reload_high_byte))
    else $error("split high byte did not reload");

  // enabled low wrap always requests
  chk_irq_low_wrap: assert property (@(posedge mclk) disable iff (!resetn)
    (low_wrap && low_overflow_irq_enable && timer_irq_enable)
      |=> irq)
    else $error("missing low byte interrupt");

  // no request while the outside enable is clear
  chk_irq_masked: assert property (@(posedge mclk) disable iff (!resetn)
    !timer_irq_enable
      |=> !irq)
    else $error("interrupt while disabled");

  // each enabled capture requests once
  chk_capture_irq: assert property (@(posedge mclk) disable iff (!resetn)
    (capture_pulse && timer_irq_enable)
      |=> irq)
    else $error("missing capture interrupt");

  // capture modes wrap to zero instead of reloading
  chk_capture_wrap: assert property (@(posedge mclk) disable iff (!resetn)
    (capture_mode_enable && low_wrap && !sfr.wr)
      |=> count_low_byte == tmr3_pkg::RESET_BYTE)
    else $error("capture mode reloaded on wrap");

  // reload bytes change only by capture or by software
  chk_reload_stable: assert property (@(posedge mclk) disable iff (!resetn)
    (!capture_pulse && !sfr.wr)
      |=> $stable({reload_high_byte, reload_low_byte}))
    else $error("reload bytes changed unasked");

  // one external edge gives one tick only
  chk_ext_single: assert property (@(posedge mclk) disable iff (!resetn)
    ext_pulse
      |=> !ext_pulse)
    else $error("external tick longer than one clock");

  // one frame start gives one event only
  chk_sof_single: assert property (@(posedge mclk) disable iff (!resetn)
    sof_pulse
      |=> !sof_pulse)
    else $error("frame event longer than one clock");

  // one oscillator fall gives one event only
  chk_lfo_single: assert property (@(posedge mclk) disable iff (!resetn)
    lfo_pulse
      |=> !lfo_pulse)
    else $error("oscillator event longer than one clock");

endmodule : tmr3_timer

// [test/tmr3_far_side.sv]
module tmr3_far_side (
  // clock
  input wire logic mclk,
  // event lines
  output logic usb_sof,
  output logic slow_internal_oscillator,
  output logic ext_clk_div8
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle levels: oscillator rests high so a fall is an event
  initial begin
    usb_sof = 1'b0;
    slow_internal_oscillator = 1'b1;
    ext_clk_div8 = 1'b0;
  end
  // frame start, held past the two sync stages
  task automatic sof_event();
    @(posedge mclk) #1 usb_sof = 1'b1;
    repeat (3) @(posedge mclk);
    #1 usb_sof = 1'b0;
  endtask : sof_event
  // one falling edge of the slow oscillator
  task automatic osc_fall();
    @(posedge mclk) #1 slow_internal_oscillator = 1'b0;
    repeat (3) @(posedge mclk);
    #1 slow_internal_oscillator = 1'b1;
  endtask : osc_fall
  // n slow rising edges, each wide enough to be synchronised
  task automatic ext_ticks(input int n);
    repeat (n) begin
      @(posedge mclk) #1 ext_clk_div8 = 1'b1;
      repeat (3) @(posedge mclk);
      #1 ext_clk_div8 = 1'b0;
      repeat (3) @(posedge mclk);
    end
  endtask : ext_ticks
endmodule : tmr3_far_side

// [test/tmr3_timer_tb.sv]
module tmr3_timer_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // short register addresses
  localparam logic [7:0] CTL = tmr3_pkg::ADDR_CONTROL;
  localparam logic [7:0] RLL = tmr3_pkg::ADDR_RELOAD_LOW;
  localparam logic [7:0] RLH = tmr3_pkg::ADDR_RELOAD_HIGH;
  localparam logic [7:0] CL = tmr3_pkg::ADDR_COUNT_LOW;
  localparam logic [7:0] CH = tmr3_pkg::ADDR_COUNT_HIGH;
  logic mclk, resetn, hi_fast, lo_fast, irq_en, irq;
  logic usb_sof, slow_internal_oscillator, ext_clk_div8;
  tmr3_pkg::tmr3_sfr_s sfr; // bus request
  logic [7:0] sfr_rdata, v;
  int mismatches, cmp_count, irq_n, cycles;
  // device under test
  tmr3_timer u_dut (.mclk(mclk), .resetn(resetn), .sfr(sfr), .sfr_rdata(sfr_rdata),
    .high_byte_fast_clock_select(hi_fast), .low_byte_fast_clock_select(lo_fast),
    .timer_irq_enable(irq_en), .ext_clk_div8(ext_clk_div8), .usb_sof(usb_sof),
    .slow_internal_oscillator(slow_internal_oscillator), .irq(irq));
  // event sources on the far side
  tmr3_far_side u_far (.mclk(mclk), .usb_sof(usb_sof),
    .slow_internal_oscillator(slow_internal_oscillator), .ext_clk_div8(ext_clk_div8));
  // 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // interrupt pulse counter and hang guard, on the falling edge where irq is settled
  always @(negedge mclk) begin
    cycles++;
    if (irq === 1'b1) irq_n++;
    if (cycles == 20000) begin
      mismatches++;
      results();
    end
  end
  // compare one value
  task automatic chk(input string what, input logic [7:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // one-cycle write pulse
  task automatic wr(input logic [7:0] a, d);
    @(posedge mclk) #1 sfr = '{1'b1, 1'b0, a, d};
    @(posedge mclk) #1 sfr = '0;
  endtask : wr
  // one-cycle read, data settled after the taking edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk) #1 sfr = '{1'b0, 1'b1, a, 8'h00};
    @(posedge mclk) #1 sfr = '0;
    d = sfr_rdata;
  endtask : rd
  task automatic rdchk(input string what, input logic [7:0] a, exp);
    logic [7:0] d;
    rd(a, d);
    chk(what, d, exp);
  endtask : rdchk
  // verdict
  task automatic results();
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results
  // main sequence
  initial begin
    sfr = '0;
    resetn = 1'b0;
    hi_fast = 1'b0;
    lo_fast = 1'b1;
    irq_en = 1'b1;
    {mismatches, cmp_count, irq_n, cycles} = '0;
    repeat (5) @(posedge mclk);
    #1 resetn = 1'b1;
    // reset values, last address unmapped
    for (int a = 0; a < 6; a++) rdchk("reset", CTL + a[7:0], 8'h00);
    wr(RLL, 8'h34);
    wr(RLH, 8'h12);
    // 16-bit wrap from 0xfffe
    wr(CL, 8'hfe);
    wr(CH, 8'hff);
    wr(CTL, 8'h04);
    repeat (6) @(posedge mclk);
    rdchk("ctl_wrap", CTL, 8'hc4);
    wr(CTL, 8'hc0);
    rdchk("high_reloaded", CH, 8'h12);
    chk("irq_wrap", irq_n[7:0], 8'h01);
    // stopped after ten ticks: 0xfffe, wrap to 0x1234, on to 0x123c
    rdchk("stopped", CL, 8'h3c);
    repeat (20) @(posedge mclk);
    rdchk("frozen", CL, 8'h3c);
    wr(CTL, 8'h00);
    rdchk("ctl_clear", CTL, 8'h00);
    // low-byte wrap interrupt in 16-bit mode
    irq_n = 0;
    wr(CL, 8'hfe);
    wr(CH, 8'h00);
    wr(CTL, 8'h24);
    repeat (6) @(posedge mclk);
    rdchk("ctl_low", CTL, 8'h64);
    wr(CTL, 8'h20);
    chk("irq_low", irq_n[7:0], 8'h01);
    // split, high stopped, low free running
    hi_fast = 1'b1;
    wr(RLL, 8'h80);
    wr(CL, 8'hfe);
    wr(CH, 8'h55);
    irq_n = 0;
    wr(CTL, 8'h08);
    repeat (20) @(posedge mclk);
    rdchk("ctl_split", CTL, 8'h48);
    rdchk("high_held", CH, 8'h55);
    chk("irq_low_masked", irq_n[7:0], 8'h00);
    // reloaded to 0x80 at the second tick, then 23 more ticks
    rdchk("low_reloaded", CL, 8'h97);
    // split high overflow interrupt
    wr(RLH, 8'h20);
    wr(CH, 8'hfe);
    wr(CTL, 8'h0c);
    repeat (6) @(posedge mclk);
    wr(CTL, 8'h08);
    chk("irq_high", irq_n[7:0], 8'h01);
    // capture on frame start, 16-bit, counter stopped
    wr(CTL, 8'h10);
    wr(CL, 8'h78);
    wr(CH, 8'h56);
    irq_n = 0;
    u_far.sof_event();
    repeat (6) @(posedge mclk);
    rdchk("cap_low", RLL, 8'h78);
    rdchk("cap_high", RLH, 8'h56);
    chk("irq_cap", irq_n[7:0], 8'h01);
    // oscillator source: frame start ignored, fall captured
    wr(CTL, 8'h12);
    wr(CL, 8'hbc);
    wr(CH, 8'h9a);
    u_far.sof_event();
    repeat (6) @(posedge mclk);
    rdchk("sof_ignored", RLL, 8'h78);
    u_far.osc_fall();
    repeat (6) @(posedge mclk);
    rdchk("osc_low", RLL, 8'hbc);
    rdchk("osc_high", RLH, 8'h9a);
    chk("irq_osc", irq_n[7:0], 8'h02);
    // split capture copies the held high byte
    wr(CH, 8'h3c);
    wr(CL, 8'hfe);
    irq_en = 1'b0;
    irq_n = 0;
    wr(CTL, 8'h18);
    u_far.sof_event();
    repeat (6) @(posedge mclk);
    rdchk("split_cap", RLH, 8'h3c);
    // low byte wrapped to zero, not to its reload, then one more tick
    rdchk("split_cap_low", RLL, 8'h01);
    chk("irq_masked", irq_n[7:0], 8'h00);
    irq_en = 1'b1;
    // divide by 12 tick
    lo_fast = 1'b0;
    wr(CTL, 8'h00);
    wr(CL, 8'h00);
    wr(CTL, 8'h04);
    repeat (120) @(posedge mclk);
    wr(CTL, 8'h00);
    rd(CL, v);
    chk("div12", {7'h00, v >= 8'h09 && v <= 8'h0b}, 8'h01);
    // external divided tick, synchronised
    wr(CL, 8'h00);
    wr(CTL, 8'h05);
    u_far.ext_ticks(5);
    repeat (6) @(posedge mclk);
    wr(CTL, 8'h01);
    rdchk("ext_ticks", CL, 8'h05);
    // second reset with the counter stopped: control and low count read back as zero
    @(posedge mclk) #1 resetn = 1'b0;
    repeat (2) @(posedge mclk);
    #1 resetn = 1'b1;
    rdchk("reset_ctl", CTL, 8'h00);
    rdchk("reset_low", CL, 8'h00);
    results();
  end
endmodule : tmr3_timer_tb
